// ==== hdl/program_flow_sequencer.sv ====
// program counter, fetch/execute pipeline and fast shadow
`timescale 1ns/10ps
`include "program_flow_map.svh"
module program_flow_sequencer #(
    parameter int PCW = `PC_W,
    parameter int SPW = `SP_W,
    parameter int DEPTH = `STACK_DEPTH
) (
    // clock and power-on reset
    input wire logic clk,
    input wire logic rst_b,
    // device reset sources
    input wire logic otherReset_b,
    input wire logic stackFaultResetEnable,
    output logic stackFaultReset,
    // program memory
    output logic [PCW-1:0] progAddr,
    input wire logic [`BYTE_W-1:0] progData,
    // data memory timing
    output logic [`WORD_W-1:0] instructionHoldingRegister,
    output logic execValid,
    output logic dataReadStrobe,
    output logic dataWriteStrobe,
    // interrupt entry
    input wire logic intRequest,
    input wire logic intHighPriority,
    output logic intAck,
    // working registers and shadow
    input wire logic [`BYTE_W-1:0] statusIn,
    input wire logic [`BYTE_W-1:0] workingAccumulator,
    input wire logic [`BYTE_W-1:0] bankSelectValue,
    output logic [`BYTE_W-1:0] shadowStatus,
    output logic [`BYTE_W-1:0] shadowAccumulator,
    output logic [`BYTE_W-1:0] shadowBank,
    output logic shadowRestore,
    // program counter low byte and holding latches
    input wire logic pcLowRead,
    input wire logic pcLowWrite,
    input wire logic [`BYTE_W-1:0] pcLowWrData,
    input wire logic latchHighWrite,
    input wire logic latchUpperWrite,
    input wire logic [`BYTE_W-1:0] latchWrData,
    output logic [`BYTE_W-1:0] pcLowByte,
    output logic [`BYTE_W-1:0] pcHighHoldingLatch,
    output logic [`UPPER_W-1:0] pcUpperHoldingLatch,
    // stack top and status access
    input wire logic topWrite,
    input wire logic [PCW-1:0] topWrData,
    input wire logic clearFullFlag,
    input wire logic clearUnderflowFlag,
    output logic [PCW-1:0] stackTop,
    output logic [SPW-1:0] returnStackPointer,
    output logic stackFullFlag,
    output logic stackUnderflowFlag
);
    // ======================================================
    // declarations
    logic resetSync1_q;
    logic resetSync2_q;
    logic faultEnSync1_q;
    logic faultEnSync2_q;
    logic faultReset_q;
    logic restart;
    logic phaseOne;
    logic phaseTwo;
    logic phaseThree;
    logic phaseFour;
    logic [PCW-1:0] pc_q;
    logic [PCW-1:0] fetchAddr_q;
    logic [PCW-1:0] progAddr_q;
    logic [`BYTE_W-1:0] lowByte_q;
    logic [`WORD_W-1:0] fetchWord_q;
    logic fetchValid_q;
    logic flush_q;
    logic [`WORD_W-1:0] ir_q;
    logic [PCW-1:0] irAddr_q;
    logic execValid_q;
    logic [`BYTE_W-1:0] pcLow_q;
    logic [`BYTE_W-1:0] latchHigh_q;
    logic [`UPPER_W-1:0] latchUpper_q;
    logic [`BYTE_W-1:0] shStatus_q;
    logic [`BYTE_W-1:0] shAcc_q;
    logic [`BYTE_W-1:0] shBank_q;
    logic restore_q;
    program_flow_pkg::flow_op_t execOp;
    logic [`WORD_W-1:0] secondWord;
    logic [PCW-1:0] nextAddr;
    logic [PCW-1:0] branchOff;
    logic [PCW-1:0] absTarget;
    logic [PCW-1:0] pcTarget;
    logic ordinary;
    logic takeInt;
    logic pcWriteTaken;
    logic changePc;
    logic fastCall;
    logic stkPush;
    logic stkPop;
    logic [PCW-1:0] stkPushData;
    logic stkFault;

    // ======================================================
    // classify a word by its program flow effect
    function automatic program_flow_pkg::flow_op_t decodeFlow(
        input logic [`WORD_W-1:0] w
    );
        if (w == `OP_PUSH) begin
            decodeFlow = program_flow_pkg::FL_PUSH;
        end else if (w == `OP_POP) begin
            decodeFlow = program_flow_pkg::FL_POP;
        end else if (w[15:1] == `OP_RET_HI) begin
            decodeFlow = program_flow_pkg::FL_RET;
        end else if (w[15:8] == `OP_GOTO_HI) begin
            decodeFlow = program_flow_pkg::FL_GOTO;
        end else if (w[15:9] == `OP_CALL_HI) begin
            decodeFlow = program_flow_pkg::FL_CALL;
        end else if (w[15:11] == `OP_BRA_HI) begin
            decodeFlow = program_flow_pkg::FL_BRA;
        end else if (w[15:11] == `OP_RELATIVE_SUBROUTINE_CALL_HI) begin
            decodeFlow = program_flow_pkg::FL_RELATIVE_SUBROUTINE_CALL;
        end else if (w[15:12] == `OP_SECOND) begin
            // lone operand word is a no-operation
            decodeFlow = program_flow_pkg::FL_NOP;
        end else begin
            decodeFlow = program_flow_pkg::FL_NONE;
        end
    endfunction

    // ======================================================
    // reset sources: pin and config bit come from outside
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            resetSync1_q <= 1'b1;
            resetSync2_q <= 1'b1;
            faultEnSync1_q <= 1'b0;
            faultEnSync2_q <= 1'b0;
        end else begin
            resetSync1_q <= otherReset_b;
            resetSync2_q <= resetSync1_q;
            faultEnSync1_q <= stackFaultResetEnable;
            faultEnSync2_q <= faultEnSync1_q;
        end
    end

    // fault becomes a one-cycle device reset
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            faultReset_q <= 1'b0;
        end else begin
            faultReset_q <= stkFault;
        end
    end

    // fault reset restarts like any other
    assign restart = faultReset_q || !resetSync2_q;

    phase_generator u_phase (
        .clk(clk),
        .rst_b(rst_b),
        .restart(restart),
        .phaseOne(phaseOne),
        .phaseTwo(phaseTwo),
        .phaseThree(phaseThree),
        .phaseFour(phaseFour)
    );

    // ======================================================
    // execute-stage decode and targets
    assign execOp = execValid_q ? decodeFlow(ir_q)
                                : program_flow_pkg::FL_NOP;
    assign ordinary = (execOp == program_flow_pkg::FL_NONE);
    // second word still arriving: low byte held, high on bus
    assign secondWord = {progData, lowByte_q};
    assign nextAddr = irAddr_q + `WORD_STEP;
    assign branchOff = {{(PCW-12){ir_q[`OFF_MSB]}}, ir_q[10:0], 1'b0};
    assign absTarget = {secondWord[11:0], ir_q[7:0], 1'b0};
    assign fastCall = (execOp == program_flow_pkg::FL_CALL)
                      && ir_q[`CALL_FAST_BIT];
    assign pcWriteTaken = phaseFour && pcLowWrite && ordinary;
    // interrupts wait for a cycle with no flow effect
    assign takeInt = phaseFour && intRequest && !pcWriteTaken
                     && (ordinary
                         || execOp == program_flow_pkg::FL_NOP);

    always_comb begin
        changePc = phaseFour;
        pcTarget = pc_q;
        if (takeInt) begin
            pcTarget = intHighPriority ? `HIGH_VECTOR : `LOW_VECTOR;
        end else if (pcWriteTaken) begin
            pcTarget = {latchUpper_q, latchHigh_q, pcLowWrData[7:1],
                        1'b0};
        end else begin
            case (execOp)
                program_flow_pkg::FL_GOTO: pcTarget = absTarget;
                program_flow_pkg::FL_CALL: pcTarget = absTarget;
                program_flow_pkg::FL_BRA: pcTarget = nextAddr + branchOff;
                program_flow_pkg::FL_RELATIVE_SUBROUTINE_CALL: pcTarget = nextAddr + branchOff;
                program_flow_pkg::FL_RET: pcTarget = stackTop;
                default: changePc = 1'b0;
            endcase
        end
    end

    // ======================================================
    // PC steps in phase one
    always_ff @(posedge clk) begin
        if (!rst_b || restart) begin
            pc_q <= `RESET_VECTOR;
        end else if (phaseOne) begin
            // two bytes per word, bit zero stays clear
            pc_q <= pc_q + `WORD_STEP;
        end else if (changePc) begin
            pc_q <= pcTarget;
        end
    end

    // fetch even byte, then odd byte, one cycle latency
    always_ff @(posedge clk) begin
        if (!rst_b || restart) begin
            fetchAddr_q <= `RESET_VECTOR;
            progAddr_q <= `RESET_VECTOR;
            lowByte_q <= '0;
            fetchWord_q <= '0;
            fetchValid_q <= 1'b0;
        end else begin
            if (phaseOne) begin
                fetchAddr_q <= pc_q;
                progAddr_q <= pc_q;
                fetchValid_q <= 1'b1;
            end
            if (phaseTwo) begin
                progAddr_q <= {fetchAddr_q[PCW-1:1], 1'b1};
            end
            if (phaseThree) begin
                lowByte_q <= progData;
            end
            if (phaseFour) begin
                fetchWord_q <= secondWord;
            end
        end
    end

    // a PC change turns the fetched word into a bubble
    always_ff @(posedge clk) begin
        if (!rst_b || restart) begin
            ir_q <= '0;
            irAddr_q <= `RESET_VECTOR;
            execValid_q <= 1'b0;
            flush_q <= 1'b0;
        end else if (phaseOne) begin
            ir_q <= fetchWord_q;
            irAddr_q <= fetchAddr_q;
            execValid_q <= fetchValid_q && !flush_q;
            flush_q <= 1'b0;
        end else if (changePc) begin
            flush_q <= 1'b1;
        end
    end

    // ======================================================
    // return stack traffic, all in phase four
    assign stkPush = phaseFour && (takeInt
        || execOp == program_flow_pkg::FL_CALL
        || execOp == program_flow_pkg::FL_RELATIVE_SUBROUTINE_CALL
        || execOp == program_flow_pkg::FL_PUSH);
    assign stkPop = phaseFour && !takeInt
        && (execOp == program_flow_pkg::FL_RET
            || execOp == program_flow_pkg::FL_POP);
    // two-word call returns past its operand word
    assign stkPushData = takeInt ? fetchAddr_q
        : (execOp == program_flow_pkg::FL_CALL) ? pc_q : nextAddr;

    return_address_stack #(
        .DEPTH(DEPTH),
        .AW(PCW),
        .PW(SPW)
    ) u_stack (
        .clk(clk),
        .rst_b(rst_b),
        .restart(restart),
        .push(stkPush),
        .pop(stkPop),
        .pushData(stkPushData),
        .topWrite(topWrite && phaseFour && !stkPush && !stkPop),
        .topWrData(topWrData),
        .faultResetEn(faultEnSync2_q),
        .clearFull(clearFullFlag),
        .clearUnderflow(clearUnderflowFlag),
        .stackTop(stackTop),
        .stackPtr(returnStackPointer),
        .fullFlag(stackFullFlag),
        .underflowFlag(stackUnderflowFlag),
        .faultEvent(stkFault)
    );

    // ======================================================
    // low byte read snapshots upper bytes
    always_ff @(posedge clk) begin
        if (!rst_b || restart) begin
            pcLow_q <= '0;
            latchHigh_q <= '0;
            latchUpper_q <= '0;
        end else if (phaseTwo && pcLowRead) begin
            pcLow_q <= nextAddr[7:0];
            latchHigh_q <= nextAddr[15:8];
            latchUpper_q <= nextAddr[PCW-1:16];
        end else if (phaseFour) begin
            // upper PC bits only reachable here
            if (latchHighWrite) begin
                latchHigh_q <= latchWrData;
            end
            if (latchUpperWrite) begin
                latchUpper_q <= latchWrData[`UPPER_W-1:0];
            end
        end
    end

    // ======================================================
    // later entry simply overwrites
    // shadow is kept through device resets, cleared by POR only
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            shStatus_q <= '0;
            shAcc_q <= '0;
            shBank_q <= '0;
        end else if (phaseFour && (takeInt || fastCall)) begin
            shStatus_q <= statusIn;
            shAcc_q <= workingAccumulator;
            shBank_q <= bankSelectValue;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b || restart) begin
            restore_q <= 1'b0;
        end else begin
            restore_q <= stkPop && ir_q[`RET_FAST_BIT]
                         && execOp == program_flow_pkg::FL_RET;
        end
    end

    // ======================================================
    // operand read phase two, write phase four
    assign dataReadStrobe = phaseTwo && ordinary;
    assign dataWriteStrobe = phaseFour && ordinary;

    // outputs
    assign progAddr = progAddr_q;
    assign instructionHoldingRegister = ir_q;
    assign execValid = execValid_q;
    assign intAck = takeInt;
    assign stackFaultReset = faultReset_q;
    assign shadowStatus = shStatus_q;
    assign shadowAccumulator = shAcc_q;
    assign shadowBank = shBank_q;
    assign shadowRestore = restore_q;
    assign pcLowByte = pcLow_q;
    assign pcHighHoldingLatch = latchHigh_q;
    assign pcUpperHoldingLatch = latchUpper_q;
endmodule

// ==== include/program_flow_map.svh ====
// constants for the program flow sequencer
`ifndef PROGRAM_FLOW_MAP_SVH
`define PROGRAM_FLOW_MAP_SVH

// ==========================================================
// widths and depths
`define PC_W 21
`define SP_W 5
`define STACK_DEPTH 31
`define BYTE_W 8
`define WORD_W 16
`define UPPER_W 5

// ==========================================================
// addresses
`define RESET_VECTOR 21'h000000
`define HIGH_VECTOR 21'h000008
`define LOW_VECTOR 21'h000018
`define WORD_STEP 21'h000002

// ==========================================================
// instruction encodings and fields
`define OP_PUSH 16'h0005
`define OP_POP 16'h0006
`define OP_RET_HI 15'h0009
`define OP_GOTO_HI 8'hEF
`define OP_CALL_HI 7'h76
`define OP_BRA_HI 5'h1A
`define OP_RELATIVE_SUBROUTINE_CALL_HI 5'h1B
`define OP_SECOND 4'hF
`define CALL_FAST_BIT 8
`define RET_FAST_BIT 0
`define OFF_MSB 10

`endif

// ==== include/program_flow_pkg.sv ====
// types shared by the program flow sequencer
package program_flow_pkg;

    // ======================================================
    // instruction cycle phases
    typedef enum logic [1:0] {
        PH_ONE,
        PH_TWO,
        PH_THREE,
        PH_FOUR
    } phase_t;

    // ======================================================
    // program flow classes of the executing word
    typedef enum logic [3:0] {
        FL_NONE,
        FL_NOP,
        FL_GOTO,
        FL_CALL,
        FL_BRA,
        FL_RELATIVE_SUBROUTINE_CALL,
        FL_RET,
        FL_PUSH,
        FL_POP
    } flow_op_t;

endpackage

// ==== hdl/phase_generator.sv ====
// four-phase instruction cycle generator
`timescale 1ns/10ps
module phase_generator (
    // clock and resets
    input wire logic clk,
    input wire logic rst_b,
    input wire logic restart,
    // phase strobes
    output logic phaseOne,
    output logic phaseTwo,
    output logic phaseThree,
    output logic phaseFour
);
    program_flow_pkg::phase_t phase_q;

    // ======================================================
    // divide by four
    always_ff @(posedge clk) begin
        if (!rst_b || restart) begin
            phase_q <= program_flow_pkg::PH_ONE;
        end else begin
            case (phase_q)
                program_flow_pkg::PH_ONE: phase_q <= program_flow_pkg::PH_TWO;
                program_flow_pkg::PH_TWO:
                    phase_q <= program_flow_pkg::PH_THREE;
                program_flow_pkg::PH_THREE:
                    phase_q <= program_flow_pkg::PH_FOUR;
                default: phase_q <= program_flow_pkg::PH_ONE;
            endcase
        end
    end

    // one-hot strobes, never overlapping
    assign phaseOne = (phase_q == program_flow_pkg::PH_ONE);
    assign phaseTwo = (phase_q == program_flow_pkg::PH_TWO);
    assign phaseThree = (phase_q == program_flow_pkg::PH_THREE);
    assign phaseFour = (phase_q == program_flow_pkg::PH_FOUR);
endmodule

// ==== hdl/return_address_stack.sv ====
// hardware return address stack with full/underflow flags
`timescale 1ns/10ps
`include "program_flow_map.svh"
module return_address_stack #(
    parameter int DEPTH = `STACK_DEPTH,
    parameter int AW = `PC_W,
    parameter int PW = `SP_W
) (
    // clock and resets
    input wire logic clk,
    input wire logic rst_b,
    input wire logic restart,
    // stack operations
    input wire logic push,
    input wire logic pop,
    input wire logic [AW-1:0] pushData,
    input wire logic topWrite,
    input wire logic [AW-1:0] topWrData,
    // flag control
    input wire logic faultResetEn,
    input wire logic clearFull,
    input wire logic clearUnderflow,
    // state
    output logic [AW-1:0] stackTop,
    output logic [PW-1:0] stackPtr,
    output logic fullFlag,
    output logic underflowFlag,
    output logic faultEvent
);
    localparam logic [PW-1:0] LAST = PW'(DEPTH);
    localparam logic [PW-1:0] BEFORE_LAST = PW'(DEPTH - 1);

    // pointer zero has no storage behind it
    logic [AW-1:0] mem [1:DEPTH];
    logic [PW-1:0] ptr_q;
    logic full_q;
    logic underflow_q;
    logic pushAtLast;
    logic pushFills;
    logic popEmpty;
    logic [PW-1:0] wrIdx;

    assign pushAtLast = push && (ptr_q == LAST);
    assign pushFills = push && (ptr_q == BEFORE_LAST);
    assign popEmpty = pop && (ptr_q == '0);
    assign wrIdx = pushAtLast ? LAST : ptr_q + PW'(1);

    // ======================================================
    // store at incremented slot, or over the top slot again when full
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wrIdx] <= pushData;
        end else if (topWrite && ptr_q != '0) begin
            mem[ptr_q] <= topWrData;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b || restart) begin
            ptr_q <= '0;
        end else if (push && !pushAtLast) begin
            ptr_q <= wrIdx;
        end else if (pop && !popEmpty) begin
            ptr_q <= ptr_q - PW'(1);
        end
    end

    // flags survive all but power-on; set beats clear
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            full_q <= 1'b0;
            underflow_q <= 1'b0;
        end else begin
            // flags set regardless of reset enable
            if (pushFills || pushAtLast) begin
                full_q <= 1'b1;
            end else if (clearFull) begin
                full_q <= 1'b0;
            end
            if (popEmpty) begin
                underflow_q <= 1'b1;
            end else if (clearUnderflow) begin
                underflow_q <= 1'b0;
            end
        end
    end

    assign faultEvent = faultResetEn && (pushFills || pushAtLast || popEmpty);
    assign stackTop = (ptr_q == '0) ? '0 : mem[ptr_q];
    assign stackPtr = ptr_q;
    assign fullFlag = full_q;
    assign underflowFlag = underflow_q;
endmodule

// ==== sim/program_flow_sequencer_monitor.sv ====
// assertion checker for the program flow sequencer ports
`timescale 1ns/10ps
module program_flow_sequencer_monitor #(
    parameter int SPW = 5
) (
    // clock and power-on reset
    input wire logic clk,
    input wire logic rst_b,
    // fault reset and data strobes
    input wire logic stackFaultReset,
    input wire logic dataReadStrobe,
    input wire logic dataWriteStrobe,
    // interrupt shadow
    input wire logic intAck,
    input wire logic [7:0] statusIn,
    input wire logic [7:0] shadowStatus,
    // stack state
    input wire logic clearFullFlag,
    input wire logic clearUnderflowFlag,
    input wire logic [SPW-1:0] returnStackPointer,
    input wire logic stackFullFlag,
    input wire logic stackUnderflowFlag
);
    // ==========
    // checks, all on the core clock
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    rd_then_wr_a: assert property (
        dataWriteStrobe |-> $past(dataReadStrobe, 2)) else $error("bad wr");
    rd_spacing_a: assert property (
        dataReadStrobe |=> !dataReadStrobe [*3]) else $error("bad rd gap");
    full_sticky_a: assert property (
        stackFullFlag && !clearFullFlag |=> stackFullFlag)
        else $error("full flag lost");
    unf_sticky_a: assert property (
        stackUnderflowFlag && !clearUnderflowFlag |=> stackUnderflowFlag)
        else $error("underflow flag lost");
    full_at_top_a: assert property (
        $rose(stackFullFlag) |-> returnStackPointer == 31)
        else $error("full flag off top");
    unf_at_zero_a: assert property (
        $rose(stackUnderflowFlag) |-> returnStackPointer == 0)
        else $error("underflow off zero");
    shadow_load_a: assert property (
        intAck |=> shadowStatus == $past(statusIn)) else $error("bad shadow");
    fault_ptr_a: assert property (
        stackFaultReset |-> ##[1:2] returnStackPointer == 0)
        else $error("pointer kept");
    // main scenarios reached
    cover property (intAck);
    cover property (stackFaultReset);
    cover property ($rose(stackUnderflowFlag));
endmodule

bind program_flow_sequencer program_flow_sequencer_monitor #(.SPW(SPW))
    mon_u (.*);

// ==== sim/program_memory_model.sv ====
// program memory model, byte wide, one cycle read latency
`timescale 1ns/10ps
module program_memory_model (
    // clock and address
    input wire logic clk,
    input wire logic [20:0] progAddr,
    // read data
    output logic [7:0] progData
);
    logic [7:0] mem [0:255];
    // even byte holds the low half of a word
    // space past the array reads zero, an ordinary word with no flow effect
    always @(posedge clk) begin
        progData <= (progAddr < 21'h000100) ? mem[progAddr[7:0]] : 8'h00;
    end
endmodule

// ==== sim/test_program_flow_sequencer.sv ====
// self-checking bench for the program flow sequencer
`timescale 1ns/10ps
module test_program_flow_sequencer;
    logic clk, rst_b, otherReset_b, stackFaultResetEnable, stackFaultReset;
    logic intRequest, intHighPriority, intAck, execValid, shadowRestore;
    logic dataReadStrobe, dataWriteStrobe, pcLowRead, pcLowWrite, topWrite;
    logic latchHighWrite, latchUpperWrite, clearFullFlag, clearUnderflowFlag;
    logic stackFullFlag, stackUnderflowFlag, fullExp, unfExp;
    logic [7:0] progData, statusIn, workingAccumulator, bankSelectValue;
    logic [7:0] shadowStatus, shadowAccumulator, shadowBank, pcLowWrData;
    logic [7:0] latchWrData, pcLowByte, pcHighHoldingLatch;
    logic [4:0] pcUpperHoldingLatch, returnStackPointer;
    logic [15:0] instructionHoldingRegister;
    logic [20:0] progAddr, stackTop, topWrData;
    int fail_count, n_tests, i;
    int q[$];

    // ==========
    // design and program memory
    program_flow_sequencer dut_u (.*);
    program_memory_model pm (.clk(clk), .progAddr(progAddr),
        .progData(progData));

    // 200 MHz core clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic chk(input logic [20:0] got, input logic [20:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic fill(input int a, input int b, input logic [15:0] w);
        for (int k = a; k < b; k++) {pm.mem[2*k+1], pm.mem[2*k]} = w;
    endtask

    task automatic por();
        rst_b <= 1'b0;
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
    endtask

    // reference stack, a push stores the address after the word
    task automatic model(input bit push, input int a);
        if (push && q.size() == 31) q[30] = a + 2;
        else if (push) q.push_back(a + 2);
        else if (q.size() == 0) unfExp = 1'b1;
        else void'(q.pop_back());
        if (push && q.size() == 31) fullExp = 1'b1;
    endtask

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // watchdog, the run needs about 500 cycles
    initial begin
        #50000;
        fail_count++;
        test_done();
    end

    // main sequence
    initial begin
        {pcLowRead, pcLowWrite, latchHighWrite, latchUpperWrite} = '0;
        {topWrite, clearFullFlag, clearUnderflowFlag, intRequest} = '0;
        {rst_b, otherReset_b, stackFaultResetEnable, intHighPriority} = 4'h4;
        {statusIn, workingAccumulator, bankSelectValue} = '0;
        {pcLowWrData, latchWrData, topWrData} = '0;
        {fullExp, unfExp, fail_count, n_tests} = '0;
        void'($urandom(37));
        fill(0, 128, 16'h0000);
        fill(0, 33, 16'h0005);
        fill(33, 66, 16'h0006);
        // armed fault reset fires on the push that fills the stack
        stackFaultResetEnable <= 1'b1;
        por();
        for (i = 0; i < 300 && stackFaultReset !== 1'b1; i++) @(negedge clk);
        chk(21'(stackFaultReset), 21'h1);
        repeat (2) @(negedge clk);
        chk(21'(returnStackPointer), 21'h0);
        chk(21'(stackFullFlag), 21'h1);
        $display("fault reset test done");
        // unarmed: fill, overwrite, unload and underflow
        @(posedge clk);
        stackFaultResetEnable <= 1'b0;
        por();
        @(negedge clk);
        chk(21'(stackFullFlag), 21'h0);
        for (i = 0; i < 20 && execValid !== 1'b1; i++) @(negedge clk);
        for (int k = 0; k < 66; k++) begin
            repeat (4) @(negedge clk);
            model(k < 33, 2 * k);
            chk(21'(returnStackPointer), 21'(q.size()));
            chk(stackTop, q.size() ? 21'(q[$]) : 21'h0);
            chk(21'({stackFullFlag, stackUnderflowFlag}),
                21'({fullExp, unfExp}));
        end
        // other reset keeps flags, software clear drops them
        fill(0, 66, 16'h0000);
        @(posedge clk);
        otherReset_b <= 1'b0;
        repeat (4) @(posedge clk);
        otherReset_b <= 1'b1;
        @(negedge clk);
        chk(21'({stackFullFlag, stackUnderflowFlag}), 21'h3);
        @(posedge clk);
        {clearFullFlag, clearUnderflowFlag} <= 2'b11;
        @(posedge clk);
        {clearFullFlag, clearUnderflowFlag} <= 2'b00;
        @(negedge clk);
        chk(21'({stackFullFlag, stackUnderflowFlag}), 21'h0);
        $display("stack test done");
        // low then high priority entry, each reloads the shadow
        for (int p = 0; p < 2; p++) begin
            @(posedge clk);
            {statusIn, workingAccumulator, bankSelectValue} <= 24'($urandom);
            intHighPriority <= (p == 1);
            intRequest <= 1'b1;
            for (i = 0; i < 40 && intAck !== 1'b1; i++) @(negedge clk);
            @(posedge clk);
            intRequest <= 1'b0;
            @(negedge clk);
            chk(21'({shadowStatus, shadowBank}),
                21'({statusIn, bankSelectValue}));
            chk(21'(shadowAccumulator), 21'(workingAccumulator));
            for (i = 0; i < 16 && progAddr !== (p ? 21'h8 : 21'h18); i++)
                @(negedge clk);
            chk(progAddr, p ? 21'h000008 : 21'h000018);
            chk(21'(returnStackPointer), 21'(p + 1));
        end
        $display("interrupt test done");
        // low byte write pulls the middle byte from its latch
        @(posedge clk);
        latchWrData <= 8'($urandom) | 8'h01;
        latchHighWrite <= 1'b1;
        repeat (4) @(posedge clk);
        latchHighWrite <= 1'b0;
        pcLowWrData <= 8'h40;
        pcLowWrite <= 1'b1;
        repeat (4) @(posedge clk);
        pcLowWrite <= 1'b0;
        // settled values only; the odd half of the fetch may be showing
        @(negedge clk);
        chk(21'(pcHighHoldingLatch), 21'(latchWrData));
        for (i = 0; i < 16 && progAddr[20:1] !== {5'h00, latchWrData, 7'h20};
             i++) @(negedge clk);
        chk(progAddr & 21'h1FFFFE, {5'h00, latchWrData, 8'h40});
        $display("latch test done");
        // fast call to word 8, fast return, branch back to the call
        fill(0, 1, 16'hED08);
        fill(1, 2, 16'hF000);
        fill(2, 3, 16'hD7FD);
        fill(8, 9, 16'h0013);
        @(posedge clk);
        {statusIn, workingAccumulator, bankSelectValue} <= 24'($urandom);
        otherReset_b <= 1'b0;
        repeat (4) @(posedge clk);
        otherReset_b <= 1'b1;
        for (i = 0; i < 40 && progAddr !== 21'h10; i++) @(negedge clk);
        chk(progAddr, 21'h000010);
        chk(21'(execValid), 21'h0);
        chk(21'(instructionHoldingRegister), 21'h00F000);
        chk(stackTop, 21'h000004);
        chk(21'({shadowStatus, shadowAccumulator}),
            21'({statusIn, workingAccumulator}));
        for (i = 0; i < 40 && shadowRestore !== 1'b1; i++) @(negedge clk);
        chk(21'(shadowRestore), 21'h1);
        for (i = 0; i < 40 && progAddr !== 21'h0; i++) @(negedge clk);
        chk(progAddr, 21'h000000);
        $display("fast call test done");
        test_done();
    end
endmodule
